// >>> core/cadc_core.sv
// clocked converter core: start, overlap tracking, result and valid timing
// Function
// - the result bus width is a parameter from 1 to 32 bits.
// - a conversion starts only on a rising edge of the conversion clock input.
// - the input sample is taken at that same edge and is what gets converted.
// - the result bus updates exactly one latency (1 us default) after its start.
// - at each update the valid strobe drops and returns high after 100 ns by default.
// - a new start is taken before the last completes if later than the minimum period.
// - an edge sooner than the minimum period after the last start is ignored.
// - the minimum period is always configured below the conversion latency.
// - results are offset binary by default, two's complement when selected.
// - codes are scaled by an input offset (default 0) and range (default 1).
`timescale 1ns/1ps
`default_nettype none
`include "cadc_consts.svh"
module cadc_core #(
  parameter int DW          = `CADC_DEF_WIDTH,
  parameter int CONV_CYC    = `CADC_CONVERT_CYC,
  parameter int MINCLK_CYC  = `CADC_MIN_CLOCK_CYC,
  parameter int VALID_CYC   = `CADC_VALID_DELAY_CYC,
  parameter int RANGE_SHIFT = `CADC_DEF_RANGE_SHIFT
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   conv_clk_i,
  input  wire logic [31:0]            sample_i,
  input  wire logic [31:0]            offset_i,
  input  wire cadc_pkg::cadc_coding_t coding_i,
  input  wire logic                   sink_ready_i,
  output logic      [DW-1:0]          data_o,
  output logic                        data_valid_o,
  output logic                        start_taken_o,
  output logic                        start_dropped_o,
  output logic                        word_o,
  output logic      [DW-1:0]          word_data_o
);
  localparam int AW   = 2;
  localparam int DEP  = 2 ** AW;
  localparam int TW   = 16;
  localparam int CW   = 16;

  // elaboration checks: widths, spacing below latency, pending depth
  if (DW < 1 || DW > 32) begin : g_bad_dw
    $error("result width out of range");
  end
  if (MINCLK_CYC >= CONV_CYC || MINCLK_CYC < 1) begin : g_bad_min
    $error("minimum period must be below conversion latency");
  end
  if ((CONV_CYC + MINCLK_CYC - 1) / MINCLK_CYC > DEP) begin : g_bad_dep
    $error("too many conversions in flight for the store");
  end
  if (CONV_CYC >= 2 ** TW - 2 || VALID_CYC < 1 || VALID_CYC >= 2 ** CW) begin : g_bad_cnt
    $error("timing counts do not fit");
  end

  logic              conv_clk_q_r;
  logic              rise;
  logic [CW-1:0]     space_cnt_r;
  logic              armed_r;
  logic              accept;
  logic [TW-1:0]     now_r;
  logic [AW-1:0]     wr_ptr_r;
  logic [AW-1:0]     rd_ptr_r;
  logic [AW:0]       pend_r;
  logic [31:0]       sample_adj;
  logic [DW-1:0]     code;
  logic [DW+TW-1:0]  mem_wr;
  logic [DW+TW-1:0]  mem_rd;
  logic [TW-1:0]     due_t;
  logic [DW-1:0]     due_code;
  logic              mem_valid_r;
  logic              due;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic [DW-1:0]     buf_out_data;
  logic              pop_buf;
  logic [CW-1:0]     valid_cnt_r;

  // edge of conversion clock, seen in the system clock
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_clk_q_r <= 1'b0;
    end else begin
      conv_clk_q_r <= conv_clk_i;
    end
  end
  assign rise = conv_clk_i && !conv_clk_q_r;

  // spacing guard: edges inside minimum period are discarded
  assign accept = rise && armed_r && (pend_r != (AW+1)'(DEP));

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      space_cnt_r <= '0;
      armed_r     <= 1'b1;
    end else if (accept) begin
      space_cnt_r <= CW'(MINCLK_CYC - 1);
      armed_r     <= 1'b0;
    end else if (space_cnt_r != '0) begin
      space_cnt_r <= space_cnt_r - CW'(1);
    end else begin
      armed_r     <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_taken_o   <= 1'b0;
      start_dropped_o <= 1'b0;
    end else begin
      start_taken_o   <= accept;
      start_dropped_o <= rise && !accept;
    end
  end

  // scaling: subtract offset, shift by range, then code the result
  assign sample_adj = (sample_i - offset_i) >>> RANGE_SHIFT;
  always_comb begin
    code = sample_adj[31 -: DW];
    if (coding_i == cadc_pkg::CADC_CODE_OFFSET_BIN) begin
      code[DW-1] = ~code[DW-1];
    end
  end

  // free-running timebase; each start stores its due time
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      now_r <= '0;
    end else begin
      now_r <= now_r + TW'(1);
    end
  end

  // due time stored one cycle early to cover the result bus output register
  assign mem_wr = {now_r + TW'(CONV_CYC - 1), code};

  cadc_mem #(
    .DW(DW + TW),
    .AW(AW)
  ) u_mem (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (accept),
    .wr_addr_i (wr_ptr_r),
    .wr_data_i (mem_wr),
    .rd_addr_i (rd_ptr_r),
    .rd_data_o (mem_rd)
  );
  assign due_t    = mem_rd[DW+TW-1:DW];
  assign due_code = mem_rd[DW-1:0];

  // read data lags a cycle after pointer moves or writes
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_valid_r <= 1'b0;
    end else begin
      // a write behind a pending entry leaves the read word alone
      mem_valid_r <= (pend_r != '0) && !due;
    end
  end
  assign due = mem_valid_r && (pend_r != '0) && (due_t == now_r);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      pend_r   <= '0;
    end else begin
      if (accept) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (due) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      pend_r <= pend_r + (AW+1)'(accept) - (AW+1)'(due);
    end
  end

  // results queue for the capturing logic; a stall past two results drops the newest
  cadc_buf #(
    .DW(DW)
  ) u_buf (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (due),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (due_code),
    .out_valid_o (buf_out_valid),
    .out_ready_i (pop_buf),
    .out_data_o  (buf_out_data)
  );
  assign pop_buf = sink_ready_i && !word_o;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_o      <= 1'b0;
      word_data_o <= '0;
    end else begin
      word_o <= buf_out_valid && pop_buf;
      if (buf_out_valid && pop_buf) begin
        word_data_o <= buf_out_data;
      end
    end
  end

  // result bus and valid strobe track the due instant directly
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o <= '0;
    end else if (due) begin
      data_o <= due_code;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_valid_o <= 1'b1;
      valid_cnt_r  <= '0;
    end else if (due) begin
      data_valid_o <= 1'b0;
      valid_cnt_r  <= CW'(VALID_CYC - 1);
    end else if (valid_cnt_r != '0) begin
      valid_cnt_r  <= valid_cnt_r - CW'(1);
    end else begin
      data_valid_o <= 1'b1;
    end
  end

  // converter cannot wait: a sink stalled past two results loses the newest
  logic unused_ready;
  assign unused_ready = buf_in_ready;
endmodule
`default_nettype wire

// >>> core/cadc_consts.svh
// timing and coding constants for the clocked converter core
`ifndef CADC_CONSTS_SVH
`define CADC_CONSTS_SVH

`define CADC_CLK_PERIOD_PS      5000
`define CADC_CONVERT_TIME_NS    1000
`define CADC_MIN_CLOCK_NS       500
`define CADC_VALID_DELAY_NS     100
// latency and spacing round down, inactive time rounds up
`define CADC_CONVERT_CYC        ((`CADC_CONVERT_TIME_NS * 1000) / `CADC_CLK_PERIOD_PS)
`define CADC_MIN_CLOCK_CYC      ((`CADC_MIN_CLOCK_NS * 1000) / `CADC_CLK_PERIOD_PS)
`define CADC_VALID_DELAY_CYC    ((`CADC_VALID_DELAY_NS * 1000 + `CADC_CLK_PERIOD_PS - 1) / `CADC_CLK_PERIOD_PS)
`define CADC_DEF_WIDTH          12
`define CADC_DEF_TWOS           1'b0
`define CADC_DEF_OFFSET         32'h0000_0000
`define CADC_DEF_RANGE_SHIFT    0

`endif

// >>> core/cadc_pkg.sv
// types for the clocked converter core
package cadc_pkg;
  typedef enum logic {
    CADC_CODE_OFFSET_BIN,
    CADC_CODE_TWOS
  } cadc_coding_t;
endpackage

// >>> core/cadc_mem.sv
// small in-flight store: result code and due time per pending conversion
`timescale 1ns/1ps
`default_nettype none
module cadc_mem #(
  parameter int DW = 32,
  parameter int AW = 2
) (
  input  wire logic          sys_clk_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [DW-1:0] wr_data_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [DW-1:0] rd_data_o
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

// >>> core/cadc_buf.sv
// two-entry valid/ready buffer on the result path
`timescale 1ns/1ps
`default_nettype none
module cadc_buf #(
  parameter int DW = 12
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          in_valid_i,
  output logic               in_ready_o,
  input  wire logic [DW-1:0] in_data_i,
  output logic               out_valid_o,
  input  wire logic          out_ready_i,
  output logic      [DW-1:0] out_data_o
);
  logic [DW-1:0] slot_r [2];
  logic          rd_ptr_r;
  logic          wr_ptr_r;
  logic [1:0]    cnt_r;
  logic          push;
  logic          pop;

  assign push        = in_valid_i && (cnt_r != 2'h2);
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o  = slot_r[rd_ptr_r];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      slot_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// >>> verif/cadc_core_chk.sv
// port assertions for the converter core
`timescale 1ns/1ps
`default_nettype none
module cadc_core_chk #(
  parameter int DW         = 12,
  parameter int CONV_CYC   = 200,
  parameter int MINCLK_CYC = 100,
  parameter int VALID_CYC  = 20
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          conv_clk_i,
  input  wire logic          start_taken_o,
  input  wire logic          start_dropped_o,
  input  wire logic          data_valid_o,
  input  wire logic [DW-1:0] data_o
);
  localparam int CD = CONV_CYC - 1;
  logic [15:0] gap_r;
  logic [15:0] low_r;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // cycles since last accepted start, saturating
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) gap_r <= 16'hFFFF;
    else if (start_taken_o) gap_r <= 16'h0001;
    else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) low_r <= 16'h0000;
    else low_r <= data_valid_o ? 16'h0000 : low_r + 16'h0001;
  end
  sequence s_rise; !conv_clk_i ##1 conv_clk_i; endsequence
  sequence s_low; !data_valid_o [*2]; endsequence
  property p_rise_answered; s_rise |=> (start_taken_o ^ start_dropped_o); endproperty
  property p_taken_cause; start_taken_o |-> $past(conv_clk_i) && !$past(conv_clk_i, 2); endproperty
  property p_gap_ok; start_taken_o |-> gap_r > MINCLK_CYC; endproperty
  property p_drop_close; start_dropped_o |-> gap_r <= MINCLK_CYC; endproperty
  property p_result_time; start_taken_o |-> ##CD s_low; endproperty
  property p_fall_cause; $fell(data_valid_o) |-> $past(start_taken_o, CD); endproperty
  property p_data_moves; $changed(data_o) |-> $fell(data_valid_o); endproperty
  property p_low_len; $rose(data_valid_o) |-> low_r == VALID_CYC; endproperty
  property p_low_cap; low_r <= VALID_CYC; endproperty
  a_rise_answered: assert property (p_rise_answered) else $error("edge not answered");
  a_taken_cause: assert property (p_taken_cause) else $error("start without edge");
  a_gap_ok: assert property (p_gap_ok) else $error("start too soon");
  a_drop_close: assert property (p_drop_close) else $error("spaced edge dropped");
  a_result_time: assert property (p_result_time) else $error("result late");
  a_fall_cause: assert property (p_fall_cause) else $error("strobe without start");
  a_data_moves: assert property (p_data_moves) else $error("bus moved alone");
  a_low_len: assert property (p_low_len) else $error("inactive time wrong");
  a_low_cap: assert property (p_low_cap) else $error("strobe stuck low");
endmodule
`default_nettype wire

// >>> verif/cadc_sink.sv
// capture-side model: stores delivered words, stalls on request
`timescale 1ns/1ps
`default_nettype none
module cadc_sink #(
  parameter int DW = 12
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          stall_i,
  input  wire logic          word_i,
  input  wire logic [DW-1:0] data_i,
  output logic               ready_o,
  output logic      [7:0]    cnt_o
);
  logic [DW-1:0] words [0:15];
  assign ready_o = !stall_i;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt_o <= 8'h00;
    else if (word_i) begin
      words[cnt_o[3:0]] <= data_i;
      cnt_o <= cnt_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// testbench for the converter core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int CONV = 20;
  localparam int MINC = 10;
  localparam int VAL  = 3;
  logic                   sys_clk_i = 1'b0;
  logic                   rst_b_i = 1'b0;
  logic                   conv_clk_i = 1'b0;
  logic [31:0]            sample_i = 32'h0000_0000;
  logic [31:0]            offset_i = 32'h0000_0000;
  cadc_pkg::cadc_coding_t coding_i = cadc_pkg::CADC_CODE_OFFSET_BIN;
  logic                   stall = 1'b1;
  logic                   sink_ready_i;
  logic [11:0]            data_o;
  logic [11:0]            word_data_o;
  logic                   data_valid_o;
  logic                   start_taken_o;
  logic                   start_dropped_o;
  logic                   word_o;
  logic [7:0]             cnt;
  logic                   dv_q = 1'b1;
  int                     fails = 0;
  int                     comparisons = 0;
  int                     cyc = 0;
  logic [11:0]            exp_q[$];
  logic [11:0]            all_q[$];
  int                     t_q[$];
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) cyc <= cyc + 1;
  cadc_core #(.DW(12), .CONV_CYC(CONV), .MINCLK_CYC(MINC), .VALID_CYC(VAL)) dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .conv_clk_i(conv_clk_i), .sample_i(sample_i),
    .offset_i(offset_i), .coding_i(coding_i), .sink_ready_i(sink_ready_i), .data_o(data_o),
    .data_valid_o(data_valid_o), .start_taken_o(start_taken_o),
    .start_dropped_o(start_dropped_o), .word_o(word_o), .word_data_o(word_data_o));
  cadc_sink #(.DW(12)) snk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .stall_i(stall),
    .word_i(word_o), .data_i(word_data_o), .ready_o(sink_ready_i), .cnt_o(cnt));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [11:0] code(input logic [31:0] s);
    logic [31:0] d;
    d = s - offset_i;
    return d[31:20] ^ (coding_i == cadc_pkg::CADC_CODE_TWOS ? 12'h000 : 12'h800);
  endfunction
  // one conversion clock pulse; expects it taken or dropped
  task automatic conv(input logic [31:0] s, input logic take);
    @(posedge sys_clk_i);
    #1;
    sample_i = s;
    conv_clk_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    conv_clk_i = 1'b0;
    sample_i = ~s; // a late sample must not leak into this result
    chk(start_taken_o, take);
    chk(start_dropped_o, !take);
    if (take) begin
      // conversion clock rose one cycle before this edge
      t_q.push_back(cyc - 1);
      exp_q.push_back(code(s));
      all_q.push_back(code(s));
    end
    @(posedge sys_clk_i);
    #1;
  endtask
  always @(posedge sys_clk_i) begin
    #1;
    if (dv_q && !data_valid_o) begin
      if (exp_q.size() == 0) chk(1, 0);
      else begin
        chk(data_o, exp_q.pop_front());
        chk(cyc, t_q.pop_front() + CONV);
      end
    end
    dv_q = data_valid_o;
  end
  initial begin
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_b_i = 1'b1;
    chk(data_o, 0);
    chk(data_valid_o, 1);
    for (int m = 0; m < 2; m++) begin
      offset_i = m ? 32'h0030_0000 : 32'h0000_0000;
      coding_i = cadc_pkg::cadc_coding_t'(m);
      conv(32'h7FFF_FFFF, 1'b1);
      repeat (MINC - 2) @(posedge sys_clk_i);
      conv(32'h8000_0000, 1'b1);
      repeat (MINC - 4) @(posedge sys_clk_i);
      conv(32'h1234_5678, 1'b0);
      conv(32'hFEDC_BA98, 1'b1);
      // sink held off across the first pass's first two results, freed before the third
      repeat (CONV - 5) @(posedge sys_clk_i);
      #1;
      stall = 1'b0;
      repeat (CONV + VAL + 10) @(posedge sys_clk_i);
      #1;
    end
    // second start lands one cycle before the first result falls due
    conv(32'h4000_0000, 1'b1);
    repeat (CONV - 5) @(posedge sys_clk_i);
    conv(32'hC000_0000, 1'b1);
    repeat (CONV + VAL + 10) @(posedge sys_clk_i);
    chk(exp_q.size(), 0);
    chk(cnt, all_q.size());
    foreach (all_q[i]) chk(snk.words[i], all_q[i]);
    results();
  end
  initial begin
    #10000;
    fails++;
    results();
  end
endmodule
bind cadc_core cadc_core_chk #(.DW(DW), .CONV_CYC(CONV_CYC), .MINCLK_CYC(MINCLK_CYC),
  .VALID_CYC(VALID_CYC)) u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .conv_clk_i(conv_clk_i), .start_taken_o(start_taken_o), .start_dropped_o(start_dropped_o),
  .data_valid_o(data_valid_o), .data_o(data_o));
`default_nettype wire
